// ==== rtl/acs_pkg.sv ====
package acs_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_NS = 10;                // mclk period
   localparam int RC_TAD_NS     = 4000;              // Internal RC bit period, typical
   localparam int RC_TAD_CYC    = (RC_TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TAD_W         = 9;                 // Width of the bit period counter
   localparam int NUM_CH        = 12;                // Analog channels with pins

   // Conversion sequence, counted in bit periods
   localparam logic [3:0] TAD_HOLD  = 4'h0;          // Period that disconnects the hold cap
   localparam logic [3:0] TAD_LAST  = 4'hB;          // Twelfth period ends the conversion
   localparam logic [3:0] TAD_WAIT  = 4'h1;          // Second period ends the abort wait

   // Byte addresses of the registers
   localparam logic [7:0] ADR_CHAN_CTRL = 8'h00;
   localparam logic [7:0] ADR_PORT_CFG  = 8'h04;
   localparam logic [7:0] ADR_CLK_FMT   = 8'h08;
   localparam logic [7:0] ADR_RES_HIGH  = 8'h0C;
   localparam logic [7:0] ADR_RES_LOW   = 8'h10;
   localparam logic [7:0] ADR_IRQ_FLAGS = 8'h14;
   localparam logic [7:0] ADR_IRQ_EN    = 8'h18;
   localparam logic [7:0] ADR_IRQ_PRIO  = 8'h1C;
   localparam logic [7:0] ADR_PIN_READ  = 8'h20;
   localparam logic [7:0] ADR_PIN_LATCH = 8'h24;
   localparam logic [7:0] ADR_PIN_DIR   = 8'h28;

   // Field positions
   localparam int CTRL_ON      = 0;                  // converter_on
   localparam int CTRL_GO      = 1;                  // Conversion go flag
   localparam int CTRL_CHS_LSB = 2;                  // channel_select, four bits
   localparam int FMT_JUSTIFY  = 7;                  // result_justify
   localparam int IRQ_DONE     = 6;                  // conv_done_flag / enable / priority

   // Implemented bits of each register
   localparam logic [7:0] MASK_CTRL = 8'h3F;
   localparam logic [7:0] MASK_PCFG = 8'h3F;
   localparam logic [7:0] MASK_FMT  = 8'h87;
   localparam logic [7:0] MASK_IRQ  = 8'h7F;

   // Values after reset
   localparam logic [7:0]  RST_REG8 = 8'h00;
   localparam logic [11:0] RST_DIR  = 12'hFFF;       // All pins inputs
   localparam logic [11:0] RST_LAT  = 12'h000;

   // Compare unit mode that arms the conversion trigger
   localparam logic [3:0] TRIG_MODE = 4'hB;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,                               // Converter off
      ST_ACQ  = 2'b01,                               // Tracking the selected channel
      ST_CONV = 2'b10,                               // Twelve bit periods running
      ST_WAIT = 2'b11                                // Settling after an abort
   } acs_state_t;

endpackage : acs_pkg

// ==== rtl/acs_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_pin_sync #(
   parameter int W = 12
) (
   // Clock, reset, enable
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic         ce,
   // Raw pins and settled levels
   input  wire logic [W-1:0] pin_raw,
   output logic      [W-1:0] pin_level
);

   if (W < 1) begin : g_bad_width
      $error("acs_pin_sync: W must be at least one");
   end

   // Three stages plus the accepted level
   typedef struct packed {
      logic [W-1:0] s1;                              // Metastable stage, read by s2 only
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;                             // Accepted level
   } acs_sync_t;

   acs_sync_t q, d;

   // A bit changes only once the second and third stages agree
   always_comb begin
      d    = q;
      d.s1 = pin_raw;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < W; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.lvl[i] = q.s3[i];
         end
      end
   end

   // Register the whole state
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign pin_level = q.lvl;

endmodule : acs_pin_sync
`default_nettype wire

// ==== rtl/acs_tad_ticker.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_tad_ticker #(
   parameter int W = 9
) (
   // Clock, reset, enable
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic         ce,
   // Control
   input  wire logic         run,                    // Count while high
   input  wire logic         clr,                    // Restart the period
   input  wire logic [W-1:0] period,                 // Cycles per bit period, at least two
   // End of each bit period
   output logic              tick
);

   if (W < acs_pkg::TAD_W) begin : g_bad_width
      $error("acs_tad_ticker: W too narrow for the RC bit period");
   end

   // Cycle counter within one bit period
   typedef struct packed {
      logic [W-1:0] cnt;
   } acs_tick_t;

   acs_tick_t q, d;

   // Last cycle of the period is flagged combinationally for the sequencer
   assign tick = run && !clr && (q.cnt == period - W'(1));

   always_comb begin
      d = q;
      if (clr || !run || tick) begin
         d.cnt = '0;
      end else begin
         d.cnt = q.cnt + W'(1);
      end
   end

   // Register the counter
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

endmodule : acs_tad_ticker
`default_nettype wire

// ==== rtl/acs_sequencer.sv ====
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer #(
   parameter int NCH = acs_pkg::NUM_CH
) (
   // Clock, reset, enable
   input  wire logic           mclk,
   input  wire logic           sys_rst,
   input  wire logic           ce,
   // AHB-Lite slave
   input  wire logic           hsel,
   input  wire logic [31:0]    haddr,
   input  wire logic [1:0]     htrans,
   input  wire logic           hwrite,
   input  wire logic [2:0]     hsize,
   input  wire logic [31:0]    hwdata,
   input  wire logic           hready,
   output logic      [31:0]    hrdata,
   output logic                hreadyout,
   output logic                hresp,
   // Port pins shared with the converter
   input  wire logic [NCH-1:0] pin_in,
   output logic      [NCH-1:0] pin_out,
   output logic      [NCH-1:0] pin_oe,
   // Analog front end
   input  wire logic           comp_hi,
   output logic                sh_connect,
   output logic      [3:0]     sh_channel,
   output logic      [9:0]     dac_code,
   // Compare unit and timebase
   input  wire logic           compare_event,
   input  wire logic [3:0]     compare_unit_mode,
   output logic                timebase_reset,
   // Status
   output logic                conv_busy
);

   if (NCH < 1 || NCH > 16) begin : g_bad_nch
      $error("acs_sequencer: NCH must lie in 1..16");
   end

   // Whole module state
   typedef struct packed {
      logic [7:0]         chan_ctrl;                 // adc_channel_control
      logic [7:0]         port_cfg;                  // adc_port_config
      logic [7:0]         clk_fmt;                   // adc_clock_format
      logic [7:0]         res_high;                  // adc_result_high
      logic [7:0]         res_low;                   // adc_result_low
      logic [7:0]         irq_flags;                 // periph_irq_flags_one
      logic [7:0]         irq_en;                    // periph_irq_enables_one
      logic [7:0]         irq_prio;                  // periph_irq_priority_one
      logic [NCH-1:0]     lat;                       // Pin output latch
      logic [NCH-1:0]     dir;                       // pin_direction_bits, one is input
      acs_pkg::acs_state_t st;                       // Sequencer state
      logic [3:0]         tadn;                      // Bit period index
      logic [9:0]         sar;                       // Decided result bits
      logic               wr_pend;                   // Write data phase pending
      logic [7:0]         waddr;                     // Address of pending write
      logic [31:0]        rdata;                     // Read data for the data phase
      logic               tb_rst;                    // Timebase reset pulse
      logic               shc;                       // Sample switch closed
      logic [9:0]         dac;                       // Trial code to the DAC
   } acs_seq_t;

   acs_seq_t q, d;

   logic [NCH-1:0]   pin_lvl;                        // Settled pin levels
   logic             tick;                           // End of a bit period
   logic             tclr;                           // Restart bit period timing
   logic             trun;                           // Bit period timing active
   logic [8:0]       tperiod;                        // Cycles per bit period
   logic [NCH-1:0]   amask;                          // Pins in analog mode
   logic             cmp;                            // Decision for the current bit
   logic [3:0]       chs;                            // Selected channel
   logic             addr_ok;                        // Valid address phase this cycle

   // Bit period length from the clock select field
   function automatic logic [8:0] tad_cycles(input logic [2:0] sel);
      if (sel[1:0] == 2'b11) begin
         tad_cycles = 9'(acs_pkg::RC_TAD_CYC);
      end else begin
         unique case (sel)
            3'h0:    tad_cycles = 9'h002;
            3'h4:    tad_cycles = 9'h004;
            3'h1:    tad_cycles = 9'h008;
            3'h5:    tad_cycles = 9'h010;
            3'h2:    tad_cycles = 9'h020;
            3'h6:    tad_cycles = 9'h040;
            default: tad_cycles = 9'h002;
         endcase
      end
   endfunction : tad_cycles

   // Channels in analog mode: config value k leaves the lowest k-3 pins digital
   function automatic logic [NCH-1:0] analog_mask(input logic [3:0] cfg);
      logic [4:0] ndig;
      ndig = (cfg > 4'h3) ? 5'(cfg - 4'h3) : 5'h00;
      for (int i = 0; i < NCH; i++) begin
         analog_mask[i] = (5'(i) >= ndig);
      end
   endfunction : analog_mask

   // One hot trial bit for bit periods one to ten, MSB first
   function automatic logic [9:0] trial_bit(input logic [3:0] n);
      trial_bit = '0;
      if (n >= 4'h1 && n <= 4'hA) begin
         trial_bit[4'hA - n] = 1'b1;
      end
   endfunction : trial_bit

   // Pins come from outside the clock domain
   acs_pin_sync #(
      .W         (NCH)
   ) u_pin_sync (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .pin_raw   (pin_in),
      .pin_level (pin_lvl)
   );

   // Bit period timing
   acs_tad_ticker #(
      .W      (acs_pkg::TAD_W)
   ) u_ticker (
      .mclk   (mclk),
      .sys_rst(sys_rst),
      .ce     (ce),
      .run    (trun),
      .clr    (tclr),
      .period (tperiod),
      .tick   (tick)
   );

   assign tperiod = tad_cycles(q.clk_fmt[2:0]);
   assign trun    = (q.st == acs_pkg::ST_CONV) || (q.st == acs_pkg::ST_WAIT);
   assign amask   = analog_mask(q.port_cfg[3:0]);
   assign chs     = q.chan_ctrl[acs_pkg::CTRL_CHS_LSB +: 4];
   assign addr_ok = hsel && htrans[1] && hready;

   // An output pin is compared by its own driven level; nothing gates on mode
   always_comb begin
      cmp = comp_hi;
      if (chs < 4'(NCH)) begin
         if (!q.dir[chs[$clog2(NCH+1)-1:0]]) begin
            cmp = q.lat[chs[$clog2(NCH+1)-1:0]];
         end
      end
   end

   // Bus, trigger and sequencer next state
   always_comb begin
      d         = q;
      tclr      = 1'b0;
      d.tb_rst  = 1'b0;

      // Write data phase; writes are word wide, bits above each register's width ignored
      if (q.wr_pend) begin
         unique case (q.waddr)
            acs_pkg::ADR_CHAN_CTRL: begin
               d.chan_ctrl = hwdata[7:0] & acs_pkg::MASK_CTRL;
               // Go only stands while the converter is on
               if (!hwdata[acs_pkg::CTRL_ON]) begin
                  d.chan_ctrl[acs_pkg::CTRL_GO] = 1'b0;
               end
            end
            acs_pkg::ADR_PORT_CFG:  d.port_cfg  = hwdata[7:0] & acs_pkg::MASK_PCFG;
            acs_pkg::ADR_CLK_FMT:   d.clk_fmt   = hwdata[7:0] & acs_pkg::MASK_FMT;
            acs_pkg::ADR_RES_HIGH:  d.res_high  = hwdata[7:0];
            acs_pkg::ADR_RES_LOW:   d.res_low   = hwdata[7:0];
            acs_pkg::ADR_IRQ_FLAGS: d.irq_flags = hwdata[7:0] & acs_pkg::MASK_IRQ;
            acs_pkg::ADR_IRQ_EN:    d.irq_en    = hwdata[7:0] & acs_pkg::MASK_IRQ;
            acs_pkg::ADR_IRQ_PRIO:  d.irq_prio  = hwdata[7:0] & acs_pkg::MASK_IRQ;
            acs_pkg::ADR_PIN_LATCH: d.lat       = hwdata[NCH-1:0];
            acs_pkg::ADR_PIN_DIR:   d.dir       = hwdata[NCH-1:0];
            default: ;                               // Unmapped or read only
         endcase
      end
      d.wr_pend = 1'b0;

      // Address phase: latch writes, fetch read data now
      if (addr_ok && hwrite) begin
         d.wr_pend = 1'b1;
         d.waddr   = haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
         d.rdata = '0;
         unique case (haddr[7:0])
            acs_pkg::ADR_CHAN_CTRL: d.rdata[7:0]     = q.chan_ctrl;
            acs_pkg::ADR_PORT_CFG:  d.rdata[7:0]     = q.port_cfg;
            acs_pkg::ADR_CLK_FMT:   d.rdata[7:0]     = q.clk_fmt;
            acs_pkg::ADR_RES_HIGH:  d.rdata[7:0]     = q.res_high;
            acs_pkg::ADR_RES_LOW:   d.rdata[7:0]     = q.res_low;
            acs_pkg::ADR_IRQ_FLAGS: d.rdata[7:0]     = q.irq_flags;
            acs_pkg::ADR_IRQ_EN:    d.rdata[7:0]     = q.irq_en;
            acs_pkg::ADR_IRQ_PRIO:  d.rdata[7:0]     = q.irq_prio;
            acs_pkg::ADR_PIN_READ:  d.rdata[NCH-1:0] = pin_lvl & ~amask;
            acs_pkg::ADR_PIN_LATCH: d.rdata[NCH-1:0] = q.lat;
            acs_pkg::ADR_PIN_DIR:   d.rdata[NCH-1:0] = q.dir;
            default:                d.rdata          = '0;
         endcase
      end

      // Compare trigger: the timebase resets even with the converter off
      if (compare_event && compare_unit_mode == acs_pkg::TRIG_MODE) begin
         d.tb_rst = 1'b1;
         if (d.chan_ctrl[acs_pkg::CTRL_ON]) begin
            d.chan_ctrl[acs_pkg::CTRL_GO] = 1'b1;
         end
      end

      // Sequencer
      unique case (q.st)
         acs_pkg::ST_IDLE: begin
            if (d.chan_ctrl[acs_pkg::CTRL_ON]) begin
               d.st = acs_pkg::ST_ACQ;
            end
         end
         acs_pkg::ST_ACQ: begin
            if (!d.chan_ctrl[acs_pkg::CTRL_ON]) begin
               d.st = acs_pkg::ST_IDLE;
            end else if (d.chan_ctrl[acs_pkg::CTRL_GO]) begin
               d.st   = acs_pkg::ST_CONV;
               d.tadn = acs_pkg::TAD_HOLD;
               d.sar  = '0;
               tclr   = 1'b1;
            end
         end
         acs_pkg::ST_CONV: begin
            if (!d.chan_ctrl[acs_pkg::CTRL_ON] || !d.chan_ctrl[acs_pkg::CTRL_GO]) begin
               // Abort at once; results stay as they were
               d.chan_ctrl[acs_pkg::CTRL_GO] = 1'b0;
               d.st   = d.chan_ctrl[acs_pkg::CTRL_ON] ? acs_pkg::ST_WAIT : acs_pkg::ST_IDLE;
               d.tadn = '0;
               tclr   = 1'b1;
            end else if (tick) begin
               if (cmp) begin
                  d.sar = q.sar | trial_bit(q.tadn);
               end
               d.tadn = q.tadn + 4'h1;
               if (q.tadn == acs_pkg::TAD_LAST) begin
                  // Load the result in the chosen alignment
                  if (q.clk_fmt[acs_pkg::FMT_JUSTIFY]) begin
                     d.res_high = {6'h00, q.sar[9:8]};
                     d.res_low  = q.sar[7:0];
                  end else begin
                     d.res_high = q.sar[9:2];
                     d.res_low  = {q.sar[1:0], 6'h00};
                  end
                  d.chan_ctrl[acs_pkg::CTRL_GO]  = 1'b0;
                  d.irq_flags[acs_pkg::IRQ_DONE] = 1'b1;  // Set wins over a same cycle clear
                  d.st   = acs_pkg::ST_ACQ;
                  d.tadn = '0;
               end
            end
         end
         acs_pkg::ST_WAIT: begin
            if (!d.chan_ctrl[acs_pkg::CTRL_ON]) begin
               d.st = acs_pkg::ST_IDLE;
            end else if (tick) begin
               d.tadn = q.tadn + 4'h1;
               if (q.tadn == acs_pkg::TAD_WAIT) begin
                  d.st   = acs_pkg::ST_ACQ;
                  d.tadn = '0;
               end
            end
         end
      endcase

      // Front end drive, registered so the pins see clean levels
      d.shc = (d.st == acs_pkg::ST_ACQ);
      d.dac = (d.st == acs_pkg::ST_CONV) ? (d.sar | trial_bit(d.tadn)) : 10'h000;
   end

   // Reset values cut to the pin count; declared before the register process uses them
   localparam logic [NCH-1:0] RST_DIR_W = acs_pkg::RST_DIR[NCH-1:0];
   localparam logic [NCH-1:0] RST_LAT_W = acs_pkg::RST_LAT[NCH-1:0];

   // Register the whole state; reset aborts any conversion
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         q           <= '0;
         q.dir       <= RST_DIR_W;
         q.lat       <= RST_LAT_W;
         q.chan_ctrl <= acs_pkg::RST_REG8;
         q.st        <= acs_pkg::ST_IDLE;
      end else if (ce) begin
         q <= d;
      end
   end

   // Outputs
   assign hrdata         = q.rdata;
   assign hreadyout      = 1'b1;                     // Zero wait states
   assign hresp          = 1'b0;                     // Always OKAY
   assign pin_out        = q.lat;
   assign pin_oe         = ~q.dir;
   assign sh_connect     = q.shc;
   assign sh_channel     = chs;
   assign dac_code       = q.dac;
   assign timebase_reset = q.tb_rst;
   assign conv_busy      = (q.st == acs_pkg::ST_CONV);

   // Size is not checked: only word accesses are expected
   logic unused_ok;
   assign unused_ok = ^{hsize, haddr[31:8], hwdata[31:8], q.irq_en, q.irq_prio};

endmodule : acs_sequencer
`default_nettype wire

// ==== testbench/acs_sequencer_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_asserts (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        ce,
   // Bus answer
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Trigger side
   input wire logic        compare_event,
   input wire logic [3:0]  compare_unit_mode,
   input wire logic        timebase_reset,
   // Converter side
   input wire logic        conv_busy,
   input wire logic        sh_connect,
   input wire logic [9:0]  dac_code,
   input wire logic [11:0] pin_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Counts cycles of one conversion; bounds a run even on the slow RC clock
   logic [12:0] busy_n_q;
   always_ff @(posedge mclk) begin
      busy_n_q <= (sys_rst || !conv_busy) ? 13'h0 : busy_n_q + 13'h1;
   end
   chk_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus answer not OKAY");
   chk_trig_pulse: assert property (compare_event && compare_unit_mode == 4'hB && ce
      |=> timebase_reset) else $error("no timebase reset after trigger");
   chk_trig_cause: assert property (timebase_reset
      |-> $past(compare_event && compare_unit_mode == 4'hB)) else $error("stray timebase reset");
   chk_hold_open: assert property (conv_busy |-> !sh_connect)
      else $error("hold switch closed while converting");
   chk_dac_idle: assert property (!conv_busy && !$past(conv_busy) |-> dac_code == 10'h0)
      else $error("trial code outside conversion");
   chk_busy_min: assert property ($rose(conv_busy) |-> conv_busy [*8])
      else $error("conversion ended too soon");
   chk_busy_max: assert property (busy_n_q <= 13'd4801)
      else $error("conversion ran too long");
   chk_oe_reset: assert property ($fell(sys_rst) |-> pin_oe == 12'h000)
      else $error("pins driven after reset");
endmodule : acs_sequencer_asserts
bind acs_sequencer acs_sequencer_asserts u_chk (.mclk, .sys_rst, .ce, .hreadyout, .hresp,
   .compare_event, .compare_unit_mode, .timebase_reset, .conv_busy, .sh_connect,
   .dac_code, .pin_oe);
`default_nettype wire

// ==== testbench/acs_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
   // Pin drive from the block and levels from outside
   input wire logic  [11:0] pin_out,
   input wire logic  [11:0] pin_oe,
   input wire logic  [11:0] ext_lvl,
   // Analog level and trial code
   input wire logic  [9:0]  ana_val,
   input wire logic  [9:0]  dac_code,
   output logic      [11:0] pin_in,
   output logic             comp_hi
);
   // A driven pin shows its own latch level, else the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
   // Ideal comparator; one level for every channel keeps the model small
   // Threshold sits at the trial code itself, so an exact level converts to its own code
   assign comp_hi = (ana_val >= dac_code);
endmodule : acs_analog_model
`default_nettype wire

// ==== testbench/acs_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb;
   logic        mclk, sys_rst, hsel, hwrite, hreadyout, hresp, comp_hi, cev;
   logic        sh_connect, conv_busy, timebase_reset;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [3:0]  mode, sh_channel;
   logic [9:0]  dac_code, ana_val;
   logic [11:0] pin_in, pin_out, pin_oe, ext_lvl;
   int          fails = 0, tests_run = 0, n, t;
   int          tad[8] = '{2, 8, 32, 400, 4, 16, 64, 400};
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   acs_sequencer DUT (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .comp_hi(comp_hi), .sh_connect(sh_connect),
      .sh_channel(sh_channel), .dac_code(dac_code), .compare_event(cev),
      .compare_unit_mode(mode), .timebase_reset(timebase_reset), .conv_busy(conv_busy));
   acs_analog_model u_ana (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
      .ana_val(ana_val), .dac_code(dac_code), .pin_in(pin_in), .comp_hi(comp_hi));
   // Compare and count
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task finish_test;
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   // One single AHB transfer; address phase held until hready
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   // Set go and count the busy cycles
   task conv(input logic [7:0] ctrl);
      bus(1'b1, 8'h00, {24'h0, ctrl | 8'h02});
      n = 0;
      repeat (6000) begin // Bus stays quiet while converting, as a sleeping core
         @(posedge mclk);
         if (conv_busy === 1'b1) n++;
         else if (n > 0) break;
      end
   endtask : conv
   task t_reset;
      bus(1'b0, 8'h00, 32'h0);
      check("ctrl reset", rd, 32'h0);
      bus(1'b0, 8'h28, 32'h0);
      check("dir reset", rd, 32'hFFF);
      bus(1'b0, 8'h40, 32'h0);
      check("unmapped", rd, 32'h0);
   endtask : t_reset
   // Every clock select, alternating justification, on a digital input pin
   task t_clock;
      bus(1'b1, 8'h04, 32'hF);
      bus(1'b0, 8'h20, 32'h0);
      check("digital pins", rd, 32'hFFF);
      bus(1'b1, 8'h00, 32'h11); // Converter on first, go later
      for (int s = 0; s < 8; s++) begin
         t = tad[s];
         bus(1'b1, 8'h08, {24'h0, s[0], 4'h0, s[2:0]});
         conv(8'h11);
         check("conv length", {31'h0, n >= 12 * t && n <= 12 * t + 1}, 32'h1);
         bus(1'b0, 8'h0C, 32'h0);
         check("result high", rd, s[0] ? 32'h02 : 32'hA9);
         bus(1'b0, 8'h10, 32'h0);
         check("result low", rd, s[0] ? 32'hA5 : 32'h40);
         bus(1'b0, 8'h14, 32'h0);
         check("done flag", rd, 32'h40);
         bus(1'b1, 8'h14, 32'h0);
         bus(1'b0, 8'h00, 32'h0);
         check("go cleared", rd, 32'h11);
         check("hold channel", {28'h0, sh_channel}, 32'h4);
      end
   endtask : t_clock
   task t_abort;
      ana_val <= 10'h155;
      bus(1'b1, 8'h0C, 32'h5A);
      bus(1'b1, 8'h08, 32'h86); // Slowest divider for the analog run
      bus(1'b1, 8'h00, 32'h13);
      repeat (100) @(posedge mclk);
      check("busy before abort", {31'h0, conv_busy}, 32'h1);
      bus(1'b1, 8'h00, 32'h11);
      @(posedge mclk);
      check("aborted", {31'h0, conv_busy}, 32'h0);
      repeat (50) @(posedge mclk);
      check("abort wait", {31'h0, sh_connect}, 32'h0);
      repeat (100) @(posedge mclk);
      check("reacquire", {31'h0, sh_connect}, 32'h1);
      bus(1'b0, 8'h0C, 32'h0);
      check("kept result", rd, 32'h5A);
      bus(1'b0, 8'h10, 32'h0);
      check("kept low", rd, 32'hA5);
   endtask : t_abort
   // Trigger pulse twenty cycles after the control write; channel acquired only when that write turns the converter on
   task trig(input logic [3:0] m, input logic [7:0] ctrl, input logic exp);
      bus(1'b1, 8'h00, {24'h0, ctrl});
      repeat (20) @(posedge mclk);
      cev <= 1'b1;
      mode <= m;
      @(posedge mclk);
      cev <= 1'b0;
      repeat (3) @(posedge mclk);
      check("trigger start", {31'h0, conv_busy}, {31'h0, exp});
      repeat (40) @(posedge mclk);
   endtask : trig
   task t_trig;
      bus(1'b1, 8'h08, 32'h00);
      trig(4'hB, 8'h11, 1'b1);
      trig(4'hB, 8'h10, 1'b0);
      trig(4'hA, 8'h11, 1'b0);
   endtask : t_trig
   task t_pins;
      bus(1'b1, 8'h04, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      check("analog pins read", rd, 32'h0);
      ana_val <= 10'h000;
      bus(1'b1, 8'h24, 32'h1);
      bus(1'b1, 8'h28, 32'hFFE);
      @(posedge mclk);
      check("pin drive", {20'h0, pin_oe}, 32'h1);
      bus(1'b1, 8'h00, 32'h01);
      conv(8'h01);
      bus(1'b0, 8'h0C, 32'h0);
      check("output pin high", rd, 32'hFF);
      bus(1'b0, 8'h10, 32'h0);
      check("output pin low", rd, 32'hC0);
   endtask : t_pins
   initial begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      cev = 1'b0;
      mode = 4'h0;
      ana_val = 10'h2A5;
      ext_lvl = 12'hFFF; // Pins stay inputs unless a test drives one
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      t_reset;
      t_clock;
      t_abort;
      t_trig;
      t_pins;
      finish_test;
   end
   // Watchdog far beyond the expected run
   initial begin
      #300000;
      fails++;
      finish_test;
   end
endmodule : acs_sequencer_tb
`default_nettype wire
